// ---- core/dpd_frame_if.sv ----
// Purpose: carries the shifted frame from the link domain to the core
// Assumes: word and count are static while the select/load strobe is high
// Notes:   no clocking block; the core samples after synchronising the strobe
`timescale 1ns/10ps
`default_nettype none
interface dpd_frame_if;
  logic [23:0] word;
  logic [4:0]  bit_count;

  modport shifter (output word, output bit_count);
  modport core    (input  word, input  bit_count);
endinterface
`default_nettype wire

// ---- core/dpd_pkg.sv ----
// Purpose: shared constants for the dual converter power-down control
// Assumes: 24-bit command word, 4-bit command, 4-bit address, 16-bit data
// Notes:   timing figures are in nanoseconds, counts derive from the core rate
package dpd_pkg;
  // frame layout
  localparam int unsigned FRAME_BITS  = 24;
  localparam int unsigned CMD_MSB     = 23;
  localparam int unsigned CMD_LSB     = 20;
  localparam int unsigned ADDR_MSB    = 19;
  localparam int unsigned ADDR_LSB    = 16;
  localparam int unsigned DATA_MSB    = 15;
  localparam int unsigned DATA_LSB    = 0;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned CNT_W       = 5;
  localparam logic [4:0]  CNT_MIN     = 5'h18;
  localparam logic [4:0]  CNT_SAT     = 5'h1F;
  localparam logic [4:0]  CNT_ONE     = 5'h01;

  // command codes
  localparam logic [3:0] CMD_WRITE      = 4'h0;
  localparam logic [3:0] CMD_UPDATE     = 4'h1;
  localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WR_UPD     = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
  localparam logic [3:0] CMD_NOP        = 4'hF;

  // address codes
  localparam logic [3:0] ADDR_CH_A = 4'h0;
  localparam logic [3:0] ADDR_CH_B = 4'h1;
  localparam logic [3:0] ADDR_ALL  = 4'hF;

  // reset values
  localparam logic [15:0] CODE_RESET = 16'h0000;

  // timing
  localparam int unsigned CORE_CLK_NS   = 10;
  localparam int unsigned WAKE_ONE_NS   = 5000;
  localparam int unsigned WAKE_BIAS5_NS = 12000;
  localparam int unsigned WAKE_BIAS3_NS = 30000;
  localparam int unsigned WAKE_ONE_CYC   = (WAKE_ONE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned WAKE_BIAS5_CYC = (WAKE_BIAS5_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned WAKE_BIAS3_CYC = (WAKE_BIAS3_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned WAKE_CNT_W     = 12;
endpackage

// ---- core/dpd_shifter.sv ----
// Purpose: serial input shifter on the link clock
// Assumes: host keeps the strobe high while the core reads the frame
// Notes:   leading bits of a long frame simply fall off the top
`timescale 1ns/10ps
`default_nettype none
module dpd_shifter (
  // link
  input  wire logic       i_sck,
  input  wire logic       i_nrst,
  input  wire logic       i_select_load_strobe,
  input  wire logic       i_sdi,
  // frame to core
  dpd_frame_if.shifter    frame
);
  logic armed_reg;

  // strobe high re-arms the counter; count itself is kept for the core
  always_ff @(posedge i_sck or negedge i_nrst or posedge i_select_load_strobe) begin
    if (!i_nrst) begin
      armed_reg <= 1'b1;
    end else if (i_select_load_strobe) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // msb-first shift on rising sck while strobe low
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      frame.word <= 24'h000000;
    end else if (!i_select_load_strobe) begin
      frame.word <= {frame.word[22:0], i_sdi}; // R10 R12
    end
  end

  // saturating bit counter, restarted at the first edge of a frame
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      frame.bit_count <= 5'h00;
    end else if (!i_select_load_strobe) begin
      if (armed_reg) begin
        frame.bit_count <= dpd_pkg::CNT_ONE;
      end else if (frame.bit_count != dpd_pkg::CNT_SAT) begin
        frame.bit_count <= frame.bit_count + dpd_pkg::CNT_ONE;
      end
    end
  end
endmodule // dpd_shifter
`default_nettype wire

// ---- core/dpd_top.sv ----
// Purpose: power-down and update control of a dual voltage-output converter
// Assumes: 100 MHz core clock, serial clock stopped while the strobe is high
// Notes:   frames shorter than 24 bits are dropped without effect
// Behaviour
// (R1) power-down command powers down addressed channel(s)
// (R2) power-down frame data is never loaded
// (R3) registers hold their contents while powered down
// (R4) powered-down channel releases its output drive
// (R5) any update powers the updated channel up
// (R6) single-channel wake delays settling by 5us
// (R7) both down shuts bias; wake 12us/30us
// (R8) host sends at least a 24-bit frame
// (R9) short codes sit msb-aligned in data field
// (R10) sample on rising sck, cmd addr data
// (R11) command and address codes decoded as listed
// (R12) 32-bit frames drop eight leading bits
// (R13) reset clears both outputs to zero scale
// (R14) reserved command or address does nothing
// (R15) wake delays counted; pending flag until done
`timescale 1ns/10ps
`default_nettype none
module dpd_top #(
  parameter logic [11:0] WAKE_ONE_CYCLES   = 12'(dpd_pkg::WAKE_ONE_CYC),
  parameter logic [11:0] WAKE_BIAS5_CYCLES = 12'(dpd_pkg::WAKE_BIAS5_CYC),
  parameter logic [11:0] WAKE_BIAS3_CYCLES = 12'(dpd_pkg::WAKE_BIAS3_CYC)
) (
  // core clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // serial link
  input  wire logic        i_sck,
  input  wire logic        i_select_load_strobe,
  input  wire logic        i_sdi,
  // supply indication, high when running from the low rail
  input  wire logic        i_supply_low,
  // converter codes
  output logic [15:0]      o_code_a,
  output logic [15:0]      o_code_b,
  output logic [15:0]      o_input_a,
  output logic [15:0]      o_input_b,
  // power and settling status
  output logic [1:0]       o_drive_en,
  output logic             o_bias_on,
  output logic [1:0]       o_settle_pending,
  output logic             o_frame_done
);
  dpd_frame_if frame_bus ();

  dpd_shifter u_shifter (
    .i_sck                (i_sck),
    .i_nrst               (i_nrst),
    .i_select_load_strobe (i_select_load_strobe),
    .i_sdi                (i_sdi),
    .frame                (frame_bus.shifter)
  );

  // channel select mask; reserved address gives no channel
  function automatic logic [1:0] chan_mask(input logic [3:0] addr);
    unique case (addr)
      dpd_pkg::ADDR_CH_A: chan_mask = 2'h1;
      dpd_pkg::ADDR_CH_B: chan_mask = 2'h2;
      dpd_pkg::ADDR_ALL:  chan_mask = 2'h3;
      default:            chan_mask = 2'h0; // R14
    endcase
  endfunction

  // strobe synchroniser: three stages, change accepted when last two agree
  logic       strb_s1_reg;
  logic       strb_s2_reg;
  logic       strb_s3_reg;
  logic       strb_level_reg;
  logic       strb_rise;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strb_s1_reg <= 1'b1;
      strb_s2_reg <= 1'b1;
      strb_s3_reg <= 1'b1;
    end else begin
      strb_s1_reg <= i_select_load_strobe;
      strb_s2_reg <= strb_s1_reg;
      strb_s3_reg <= strb_s2_reg;
    end
  end

  // filtered level; reset high so a strobe idle at release is no frame
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strb_level_reg <= 1'b1;
    end else if (strb_s2_reg == strb_s3_reg) begin
      strb_level_reg <= strb_s3_reg;
    end
  end

  assign strb_rise = strb_s2_reg & strb_s3_reg & ~strb_level_reg; // R10

  // rail flag synchroniser; the flag comes straight from a pin
  logic       supply_s1_reg;
  logic       supply_s2_reg;
  logic       supply_s3_reg;
  logic       supply_low_reg;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      supply_s1_reg <= 1'b0;
      supply_s2_reg <= 1'b0;
      supply_s3_reg <= 1'b0;
    end else begin
      supply_s1_reg <= i_supply_low;
      supply_s2_reg <= supply_s1_reg;
      supply_s3_reg <= supply_s2_reg;
    end
  end

  // filtered rail flag; a blip shorter than two cycles never picks the wake
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      supply_low_reg <= 1'b0;
    end else if (supply_s2_reg == supply_s3_reg) begin
      supply_low_reg <= supply_s3_reg;
    end
  end

  // frame decode; word is static once the strobe has risen
  logic        frame_ok;
  logic [3:0]  cmd;
  logic [3:0]  addr;
  logic [15:0] data;
  logic [1:0]  sel;
  logic        exec;

  assign frame_ok = (frame_bus.bit_count >= dpd_pkg::CNT_MIN); // R8
  assign cmd      = frame_bus.word[dpd_pkg::CMD_MSB:dpd_pkg::CMD_LSB]; // R11
  assign addr     = frame_bus.word[dpd_pkg::ADDR_MSB:dpd_pkg::ADDR_LSB]; // R11
  // data taken whole; low don't-care bits of short codes pass untouched
  assign data     = frame_bus.word[dpd_pkg::DATA_MSB:dpd_pkg::DATA_LSB]; // R9
  assign sel      = chan_mask(addr);
  assign exec     = strb_rise & frame_ok;

  // per-command actions, as channel masks
  logic [1:0] wr_mask;
  logic [1:0] upd_mask;
  logic [1:0] pd_mask;

  always_comb begin
    wr_mask    = 2'h0;
    upd_mask   = 2'h0;
    pd_mask    = 2'h0;
    if (exec) begin
      unique case (cmd)
        dpd_pkg::CMD_WRITE: begin
          wr_mask = sel;
        end
        dpd_pkg::CMD_UPDATE: begin
          upd_mask = sel;
        end
        dpd_pkg::CMD_WR_UPD_ALL: begin
          wr_mask  = sel;
          // only with a valid address, else the frame is ignored
          upd_mask = (sel != 2'h0) ? 2'h3 : 2'h0; // R14
        end
        dpd_pkg::CMD_WR_UPD: begin
          wr_mask    = sel;
          upd_mask   = sel;
        end
        dpd_pkg::CMD_POWER_DOWN: begin
          pd_mask = sel; // R1 R2
        end
        dpd_pkg::CMD_NOP: begin
          wr_mask = 2'h0;
        end
        default: begin
          wr_mask = 2'h0; // R14
        end
      endcase
    end
  end

  // input registers; power-down frames never reach them
  logic [15:0] input_reg [2];
  logic [15:0] dac_reg [2];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      input_reg[0] <= dpd_pkg::CODE_RESET;
      input_reg[1] <= dpd_pkg::CODE_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_mask[i]) begin
          input_reg[i] <= data; // R2 R3
        end
      end
    end
  end

  // converter registers; write-and-update loads the new word straight in
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dac_reg[0] <= dpd_pkg::CODE_RESET; // R13
      dac_reg[1] <= dpd_pkg::CODE_RESET; // R13
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (upd_mask[i]) begin
          dac_reg[i] <= (wr_mask[i]) ? data : input_reg[i]; // R3 R5
        end
      end
    end
  end

  // power state per channel; update wins over power-down in one frame
  logic [1:0] down_reg;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      down_reg <= 2'h0;
    end else begin
      down_reg <= (down_reg | pd_mask) & ~upd_mask; // R1 R5
    end
  end

  // wake delay chosen from the state before the update
  logic        both_down;
  logic [11:0] bias_wake;
  logic [11:0] wake_load;

  assign both_down = &down_reg; // R7
  assign bias_wake = supply_low_reg ? WAKE_BIAS3_CYCLES : WAKE_BIAS5_CYCLES; // R7
  assign wake_load = both_down ? bias_wake : WAKE_ONE_CYCLES; // R6 R7

  // settle counters; a fresh wake reloads, otherwise count down to zero
  logic [11:0] settle_cnt_reg [2];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      settle_cnt_reg[0] <= 12'h000;
      settle_cnt_reg[1] <= 12'h000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (upd_mask[i] && down_reg[i]) begin
          settle_cnt_reg[i] <= wake_load; // R6 R7 R15
        end else if (settle_cnt_reg[i] != 12'h000) begin
          settle_cnt_reg[i] <= settle_cnt_reg[i] - 12'h001; // R15
        end
      end
    end
  end

  // bias status: off while both down, back on once woken
  logic bias_on_reg;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bias_on_reg <= 1'b1;
    end else begin
      bias_on_reg <= ~(&((down_reg | pd_mask) & ~upd_mask)); // R7
    end
  end

  // execution pulse for observers
  logic frame_done_reg;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      frame_done_reg <= 1'b0;
    end else begin
      frame_done_reg <= exec;
    end
  end

  // outputs; codes stay held while the drive is released
  assign o_code_a         = dac_reg[0];
  assign o_code_b         = dac_reg[1];
  assign o_input_a        = input_reg[0];
  assign o_input_b        = input_reg[1];
  assign o_drive_en       = ~down_reg; // R4
  assign o_bias_on        = bias_on_reg;
  assign o_settle_pending = {settle_cnt_reg[1] != 12'h000,
                             settle_cnt_reg[0] != 12'h000}; // R15
  assign o_frame_done     = frame_done_reg;
endmodule // dpd_top
`default_nettype wire

// ---- testbench/dpd_host_model.sv ----
// Purpose: serial host that shifts command frames into the converter
// Assumes: 32 ns link clock, running only inside a frame
// Notes:   released data line shows the inverse of the last bit
`timescale 1ns/10ps
`default_nettype none
module dpd_host_model (
  // serial link toward the converter
  output logic o_sck,
  output logic o_select_load_strobe,
  output logic o_sdi
);
  initial begin
    o_sck = 1'b0;
    o_select_load_strobe = 1'b1;
    o_sdi = 1'b0;
  end
  // msb first; data set up half a period before each rising clock
  task automatic send(input logic [31:0] word, input int nbits);
    o_select_load_strobe = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_sdi = word[i];
      #16 o_sck = 1'b1;
      #16 o_sck = 1'b0;
    end
    #16 o_select_load_strobe = 1'b1;
    o_sdi = ~o_sdi;
  endtask
endmodule // dpd_host_model
`default_nettype wire

// ---- testbench/dpd_top_sva.sv ----
// Purpose: port checks for the power-down control
// Assumes: one core clock domain, async active-low reset
// Notes:   the pending run is only matched against the three wake counts
`timescale 1ns/10ps
`default_nettype none
module dpd_top_sva #(
  parameter logic [11:0] WAKE_ONE_CYCLES   = 12'h005,
  parameter logic [11:0] WAKE_BIAS5_CYCLES = 12'h00C,
  parameter logic [11:0] WAKE_BIAS3_CYCLES = 12'h01E
) (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  // watched outputs
  input wire logic [15:0] o_code_a,
  input wire logic [15:0] o_code_b,
  input wire logic [15:0] o_input_a,
  input wire logic [15:0] o_input_b,
  input wire logic [1:0]  o_drive_en,
  input wire logic        o_bias_on,
  input wire logic [1:0]  o_settle_pending,
  input wire logic        o_frame_done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  logic [11:0] pa_reg;
  logic [11:0] pb_reg;
  // run length of each pending flag, so the wake count can be matched exactly
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pa_reg <= 12'h000;
      pb_reg <= 12'h000;
    end else begin
      pa_reg <= o_settle_pending[0] ? pa_reg + 12'h001 : 12'h000;
      pb_reg <= o_settle_pending[1] ? pb_reg + 12'h001 : 12'h000;
    end
  end
  reset_value_a: assert property (
    !$past(i_nrst) |-> o_code_a == 16'h0000 && o_code_b == 16'h0000 && o_drive_en == 2'h3)
    else $error("outputs not cleared after reset");
  bias_track_a: assert property (o_bias_on == (o_drive_en != 2'h0))
    else $error("bias state does not follow channel power");
  done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
    else $error("frame done longer than one cycle");
  change_done_a: assert property (
    $changed({o_code_a, o_code_b, o_input_a, o_input_b, o_drive_en}) |-> o_frame_done)
    else $error("state changed without an executed frame");
  down_hold_a: assert property (
    $fell(o_drive_en[0]) |-> $stable(o_code_a) && $stable(o_input_a))
    else $error("channel a registers disturbed by power down");
  down_hold_b_a: assert property (
    $fell(o_drive_en[1]) |-> $stable(o_code_b) && $stable(o_input_b) && o_frame_done)
    else $error("channel b power down not clean");
  wake_pend_a: assert property (
    $rose(o_drive_en[0]) |-> o_settle_pending[0] && o_code_a == o_input_a)
    else $error("channel a woke without update or pending");
  pend_len_a: assert property ($fell(o_settle_pending[0]) |-> pa_reg == WAKE_ONE_CYCLES
    || pa_reg == WAKE_BIAS5_CYCLES || pa_reg == WAKE_BIAS3_CYCLES)
    else $error("channel a pending length wrong");
  pend_len_b_a: assert property ($fell(o_settle_pending[1]) |-> pb_reg == WAKE_ONE_CYCLES
    || pb_reg == WAKE_BIAS5_CYCLES || pb_reg == WAKE_BIAS3_CYCLES)
    else $error("channel b pending length wrong");
endmodule // dpd_top_sva

bind dpd_top dpd_top_sva #(.WAKE_ONE_CYCLES(WAKE_ONE_CYCLES),
  .WAKE_BIAS5_CYCLES(WAKE_BIAS5_CYCLES), .WAKE_BIAS3_CYCLES(WAKE_BIAS3_CYCLES)) u_dpd_top_sva (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .o_code_a(o_code_a), .o_code_b(o_code_b),
  .o_input_a(o_input_a), .o_input_b(o_input_b), .o_drive_en(o_drive_en),
  .o_bias_on(o_bias_on), .o_settle_pending(o_settle_pending), .o_frame_done(o_frame_done));
`default_nettype wire

// ---- testbench/dpd_top_test.sv ----
// Purpose: self-checking bench for the power-down control
// Assumes: wake counts shortened to 5, 12 and 30 core cycles
// Notes:   rows hold plain commands, hand tests the awkward frames
`timescale 1ns/10ps
`default_nettype none
module dpd_top_test;
  localparam logic [11:0] W0 = 12'h000;
  localparam logic [11:0] W1 = 12'h005;
  localparam logic [11:0] W5 = 12'h00C;
  localparam logic [11:0] W3 = 12'h01E;
  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] data;
    logic [15:0] ca;
    logic [15:0] cb;
    logic [15:0] ia;
    logic [15:0] ib;
    logic [1:0]  en;
    logic [11:0] pa;
    logic [11:0] pb;
  } dpd_row_t;
  logic        clk, nrst, supply_low, sck, strobe, sdi, bias, done;
  logic [15:0] code_a, code_b, input_a, input_b;
  logic [1:0]  drive_en, pend;
  int          pc_a, pc_b, dn, err_count, cmp_count;
  int          tot_a, tot_b, tot_dn, base_a, base_b, base_dn;
  // command, data, then expected codes, inputs, drive and pending runs
  dpd_row_t rows [13] = '{
    '{8'h30, 16'h1234, 16'h1234, 16'h0000, 16'h1234, 16'h0000, 2'h3, W0, W0},
    '{8'h01, 16'hABCD, 16'h1234, 16'h0000, 16'h1234, 16'hABCD, 2'h3, W0, W0},
    '{8'h11, 16'h0000, 16'h1234, 16'hABCD, 16'h1234, 16'hABCD, 2'h3, W0, W0},
    '{8'h20, 16'h5555, 16'h5555, 16'hABCD, 16'h5555, 16'hABCD, 2'h3, W0, W0},
    '{8'h3F, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0FF0, 2'h3, W0, W0},
    '{8'hF0, 16'hFFFF, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0FF0, 2'h3, W0, W0},
    '{8'h70, 16'h1111, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0FF0, 2'h3, W0, W0},
    '{8'h25, 16'h2222, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0FF0, 2'h3, W0, W0},
    '{8'h40, 16'h9999, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0FF0, 2'h2, W0, W0},
    '{8'h00, 16'h7770, 16'h0FF0, 16'h0FF0, 16'h7770, 16'h0FF0, 2'h2, W0, W0},
    '{8'h10, 16'h0000, 16'h7770, 16'h0FF0, 16'h7770, 16'h0FF0, 2'h3, W1, W0},
    '{8'h4F, 16'h0000, 16'h7770, 16'h0FF0, 16'h7770, 16'h0FF0, 2'h0, W0, W0},
    '{8'h21, 16'h1230, 16'h7770, 16'h1230, 16'h7770, 16'h1230, 2'h3, W5, W5}};
  dpd_top #(.WAKE_ONE_CYCLES(W1), .WAKE_BIAS5_CYCLES(W5), .WAKE_BIAS3_CYCLES(W3)) u_dpd_top (
    .i_core_clk(clk), .i_nrst(nrst), .i_sck(sck), .i_select_load_strobe(strobe),
    .i_sdi(sdi), .i_supply_low(supply_low), .o_code_a(code_a), .o_code_b(code_b),
    .o_input_a(input_a), .o_input_b(input_b), .o_drive_en(drive_en), .o_bias_on(bias),
    .o_settle_pending(pend), .o_frame_done(done));
  dpd_host_model u_dpd_host_model (.o_sck(sck), .o_select_load_strobe(strobe), .o_sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // running totals; each frame takes its share by difference, one writer each
  always @(posedge clk) begin
    tot_a <= tot_a + int'(pend[0]);
    tot_b <= tot_b + int'(pend[1]);
    tot_dn <= tot_dn + int'(done);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic state(input logic [15:0] ca, cb, ia, ib, input logic [1:0] en);
    chk("code a", ca, code_a);
    chk("code b", cb, code_b);
    chk("input a", ia, input_a);
    chk("input b", ib, input_b);
    chk("drive en", 16'(en), 16'(drive_en));
    chk("bias", 16'(en != 2'h0), 16'(bias));
  endtask
  // waits for done under a bound, then long enough for the slowest wake
  task automatic frame(input logic [31:0] word, input int nbits);
    base_a = tot_a;
    base_b = tot_b;
    base_dn = tot_dn;
    u_dpd_host_model.send(word, nbits);
    for (int k = 0; k < 20 && tot_dn == base_dn; k++) @(negedge clk);
    repeat (40) @(negedge clk);
    pc_a = tot_a - base_a;
    pc_b = tot_b - base_b;
    dn = tot_dn - base_dn;
  endtask
  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    supply_low = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    state(16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h3);
    $display("test reset done");
    foreach (rows[i]) begin
      frame({8'h00, rows[i].op, rows[i].data}, 24);
      state(rows[i].ca, rows[i].cb, rows[i].ia, rows[i].ib, rows[i].en);
      chk("wake a", 16'(rows[i].pa), 16'(pc_a));
      chk("wake b", 16'(rows[i].pb), 16'(pc_b));
      chk("done", 16'h0001, 16'(dn));
      $display("test row %0d done", i);
    end
    supply_low = 1'b1;
    frame(32'h004F0000, 24);
    frame(32'h001F0000, 24);
    chk("low wake a", 16'(W3), 16'(pc_a));
    chk("low wake b", 16'(W3), 16'(pc_b));
    $display("test low supply wake done");
    frame(32'hA5314321, 32);
    state(16'h7770, 16'h4321, 16'h7770, 16'h4321, 2'h3);
    $display("test long frame done");
    frame(32'h00030ABC, 20);
    state(16'h7770, 16'h4321, 16'h7770, 16'h4321, 2'h3);
    chk("short done", 16'h0000, 16'(dn));
    $display("test short frame done");
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    state(16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h3);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    state(16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h3);
    $display("test second reset done");
    report_and_stop();
  end
  // about five times the expected run length
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule // dpd_top_test
`default_nettype wire
